// ===== bus_cycle_sequencer.v
// bus_cycle_sequencer: external bus cycle sequencer with five timed phases
// assumes read data synchronous to i_mclk, one clock domain; handshake may be asynchronous in async mode
// assumes the register port and cycle requests come from logic on i_mclk
//
// Contract
// RULE1: every cycle runs address setup, command delay, write setup, access, hold
// RULE2: phase lengths programmable per chip select; command delay 0..3 units
// RULE3: address setup 1..2 units, plus 0..3 on window change, max 5
// RULE4: write setup / multiplexed tristate phase lasts 0 or 1 unit
// RULE5: address and write data hold phase lasts 0..3 units
// RULE6: access phase 1..32 units; handshake may lengthen it when enabled
// RULE7: handshake inactive at sampling point inserts one waitstate, sample again
// RULE8: handshake active at sampling point ends the running cycle
// RULE9: synchronous and asynchronous handshake modes use different sampling points
// RULE10: read data captured on the edge that drops strobe and changes address; the address here holds until the next request
// RULE11: strobe asserted after command delay, through access, released at hold
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "bus_seq_defines.vh"

module bus_cycle_sequencer (
    // clock and reset
    input wire i_mclk,
    input wire i_rst_b,
    // register port
    input wire [3:0] i_reg_addr,
    input wire [15:0] i_reg_wdata,
    input wire i_reg_wr,
    input wire i_reg_rd,
    output reg [15:0] o_reg_rdata,
    // cycle request
    input wire i_req,
    input wire i_req_write,
    input wire [1:0] i_req_cs,
    input wire [23:0] i_req_addr,
    input wire [15:0] i_req_wdata,
    input wire i_req_upper,
    output reg o_busy,
    output reg o_done,
    output reg [15:0] o_rdata,
    // external bus
    output reg [23:0] o_bus_addr,
    output reg [3:0] o_cs_b,
    output reg o_rd_b,
    output reg o_wr_b,
    output reg o_upper_byte_enable_b,
    output reg [15:0] o_data_out,
    output reg o_data_oe,
    input wire [15:0] i_data_in,
    input wire i_ready_b
);

    // ****************
    // declarations
    // ****************
    // one timing word per chip select
    reg [15:0] chip_select_timing_config [0:3];
    reg [7:0] unit_div;
    reg [7:0] div_cnt;
    reg tick;
    reg [6:0] state;
    reg [6:0] next_state;
    reg [1:0] cur_cs;
    reg [1:0] last_cs;
    reg cur_write;
    reg [15:0] cur_wdata;
    reg window_changed;
    reg ready_sync;
    reg ready_async_q1;
    reg ready_async_q2;
    reg load;
    reg [5:0] load_len;
    reg ready_seen;
    wire timer_done;
    wire [1:0] sel_cs;
    wire win_now;
    wire [15:0] cfg;
    wire [5:0] len_ab;
    wire [5:0] len_c;
    wire [5:0] len_d;
    wire [5:0] len_e;
    wire [5:0] len_f;
    wire rdy_en;
    wire rdy_async;
    wire ready_now;
    wire phase_end;
    integer k;

    // ****************
    // configuration decode
    // ****************
    // while idle the requested select is decoded, so the first phase already
    // uses the new timing word and the window-change extension
    assign sel_cs = (state == `PH_IDLE) ? i_req_cs : cur_cs;
    assign win_now = (state == `PH_IDLE) ? (i_req_cs != last_cs) : window_changed; // RULE3
    // fields of the selected chip-select timing word
    assign cfg = chip_select_timing_config[sel_cs];
    assign len_ab = {5'h00, cfg[`CFG_AB_LSB]} + 6'h01 +
        (win_now ? {4'h0, cfg[`CFG_AB_EXT_LSB+1:`CFG_AB_EXT_LSB]} : 6'h00); // RULE3
    assign len_c = {4'h0, cfg[`CFG_C_LSB+1:`CFG_C_LSB]}; // RULE2
    assign len_d = {5'h00, cfg[`CFG_D_BIT]}; // RULE4
    assign len_e = {1'b0, cfg[`CFG_E_LSB+4:`CFG_E_LSB]} + 6'h01; // RULE6
    assign len_f = {4'h0, cfg[`CFG_F_LSB+1:`CFG_F_LSB]}; // RULE5
    assign rdy_en = cfg[`CFG_RDY_EN_BIT];
    assign rdy_async = cfg[`CFG_RDY_ASYNC_BIT];

    // ****************
    // register port
    // ****************
    // config words steer phase lengths; status shows the sequencer state
    // unmapped indices read as zero and ignore writes
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (k = 0; k < 4; k = k + 1) begin
                chip_select_timing_config[k] <= `CFG_RESET;
            end
            unit_div <= `UNIT_DIV_RESET;
            o_reg_rdata <= 16'h0000;
        end else begin
            if (i_reg_wr) begin
                case (i_reg_addr)
                    `REG_CFG0: chip_select_timing_config[0] <= i_reg_wdata; // RULE2
                    `REG_CFG1: chip_select_timing_config[1] <= i_reg_wdata;
                    `REG_CFG2: chip_select_timing_config[2] <= i_reg_wdata;
                    `REG_CFG3: chip_select_timing_config[3] <= i_reg_wdata;
                    `REG_UNIT_DIV: unit_div <= i_reg_wdata[7:0];
                    default: ;
                endcase
            end
            if (i_reg_rd) begin
                case (i_reg_addr)
                    `REG_CFG0: o_reg_rdata <= chip_select_timing_config[0];
                    `REG_CFG1: o_reg_rdata <= chip_select_timing_config[1];
                    `REG_CFG2: o_reg_rdata <= chip_select_timing_config[2];
                    `REG_CFG3: o_reg_rdata <= chip_select_timing_config[3];
                    `REG_STATUS: o_reg_rdata <= {5'h00, last_cs, cur_cs, state};
                    `REG_UNIT_DIV: o_reg_rdata <= {8'h00, unit_div};
                    default: o_reg_rdata <= 16'h0000;
                endcase
            end else begin
                o_reg_rdata <= 16'h0000;
            end
        end
    end

    // ****************
    // unit divider
    // ****************
    // count clocks within a unit; restart with each phase load so every phase
    // begins on a unit boundary
    // limitation: lowering the divider mid-unit lets the count wrap through 255
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div_cnt <= 8'h00;
        end else if (load || tick) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    // tick marks the last clock of a unit, so n units last n*(div+1) clocks
    always @* begin
        tick = (div_cnt == unit_div); // RULE2
    end

    phase_timer u_timer (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_load(load),
        .i_len(load_len),
        .i_tick(tick),
        .o_done(timer_done)
    );

    // ****************
    // handshake sampling
    // ****************
    // async path gets two stages to settle a pin that may move at any time;
    // sync mode takes the pin through one stage, so it reacts to the pin one clock earlier than async
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ready_sync <= 1'b0;
            ready_async_q1 <= 1'b0;
            ready_async_q2 <= 1'b0;
        end else begin
            ready_sync <= !i_ready_b;
            ready_async_q1 <= !i_ready_b;
            ready_async_q2 <= ready_async_q1;
        end
    end
    assign ready_now = rdy_async ? ready_async_q2 : ready_sync; // RULE9

    // ****************
    // phase sequencing
    // ****************
    // a zero-length phase is skipped by loading the next one directly
    assign phase_end = timer_done;

    always @* begin
        next_state = state;
        load = 1'b0;
        load_len = 6'h00;
        ready_seen = 1'b0;
        case (state)
            // a request loads the address setup length at once
            `PH_IDLE: begin
                if (i_req) begin
                    next_state = `PH_ADDR; // RULE1
                    load = 1'b1;
                    load_len = len_ab;
                end
            end
            // zero-length command delay and write setup phases are skipped
            `PH_ADDR: begin
                if (phase_end) begin
                    if (len_c != 6'h00) begin
                        next_state = `PH_CMD;
                        load_len = len_c;
                    end else if (len_d != 6'h00) begin
                        next_state = `PH_WSET;
                        load_len = len_d;
                    end else begin
                        next_state = `PH_ACC;
                        load_len = len_e;
                    end
                    load = 1'b1;
                end
            end
            `PH_CMD: begin
                if (phase_end) begin
                    next_state = (len_d != 6'h00) ? `PH_WSET : `PH_ACC; // RULE1
                    load_len = (len_d != 6'h00) ? len_d : len_e;
                    load = 1'b1;
                end
            end
            `PH_WSET: begin
                if (phase_end) begin
                    next_state = `PH_ACC;
                    load_len = len_e;
                    load = 1'b1;
                end
            end
            // the handshake counts only once the programmed access units are over
            `PH_ACC, `PH_RDY: begin
                if (phase_end) begin
                    ready_seen = !rdy_en || ready_now;
                    if (!ready_seen) begin
                        next_state = `PH_RDY; // RULE7
                        load_len = 6'h01;
                        load = 1'b1;
                    end else if (len_f != 6'h00) begin
                        next_state = `PH_HOLD; // RULE8
                        load_len = len_f;
                        load = 1'b1;
                    end else begin
                        next_state = `PH_IDLE;
                    end
                end
            end
            // hold ends the cycle without a further load
            `PH_HOLD: begin
                if (phase_end) begin
                    next_state = `PH_IDLE;
                end
            end
            default: next_state = `PH_IDLE;
        endcase
    end

    // ****************
    // bus outputs
    // ****************
    // strobes and data enable follow the phase; read data latched as strobe rises
    // write data stays driven through hold so it is stable after the strobe rises
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= `PH_IDLE;
            cur_cs <= 2'h0;
            last_cs <= 2'h0;
            cur_write <= 1'b0;
            cur_wdata <= 16'h0000;
            window_changed <= 1'b0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_rdata <= 16'h0000;
            o_bus_addr <= 24'h000000;
            o_cs_b <= 4'hF;
            o_rd_b <= 1'b1;
            o_wr_b <= 1'b1;
            o_upper_byte_enable_b <= 1'b1;
            o_data_out <= 16'h0000;
            o_data_oe <= 1'b0;
        end else begin
            state <= next_state;
            o_done <= 1'b0;
            if (state == `PH_IDLE && i_req) begin
                cur_cs <= i_req_cs;
                window_changed <= (i_req_cs != last_cs); // RULE3
                cur_write <= i_req_write;
                cur_wdata <= i_req_wdata;
                o_busy <= 1'b1;
                o_bus_addr <= i_req_addr;
                o_upper_byte_enable_b <= !i_req_upper;
                o_cs_b <= ~(4'h1 << i_req_cs);
            end
            // write data driven from write setup on; strobe on once access starts
            if (next_state == `PH_WSET || next_state == `PH_ACC) begin
                o_data_oe <= cur_write;
                o_data_out <= cur_wdata;
            end
            if (next_state == `PH_ACC && state != `PH_ACC && state != `PH_RDY) begin
                o_rd_b <= cur_write; // RULE11
                o_wr_b <= !cur_write; // RULE11
            end
            // end of access: release strobe, latch read data on the same edge
            if ((state == `PH_ACC || state == `PH_RDY) && next_state != `PH_RDY && phase_end) begin
                o_rd_b <= 1'b1; // RULE11
                o_wr_b <= 1'b1;
                if (!cur_write) begin
                    o_rdata <= i_data_in; // RULE10
                end
            end
            // cycle finished: drop select and bus drive
            if (state != `PH_IDLE && next_state == `PH_IDLE) begin
                o_busy <= 1'b0;
                o_done <= 1'b1;
                o_cs_b <= 4'hF;
                o_data_oe <= 1'b0;
                o_upper_byte_enable_b <= 1'b1;
                last_cs <= cur_cs;
            end
        end
    end

endmodule // bus_cycle_sequencer

`default_nettype wire

// ===== bus_seq_defines.vh
// bus cycle sequencer constants: phase codes, field positions, register map, reset values
// assumes inclusion by bare name from the design files
`ifndef BUS_SEQ_DEFINES_VH
`define BUS_SEQ_DEFINES_VH

// phase state codes, one-hot
`define PH_IDLE 7'h01
`define PH_ADDR 7'h02
`define PH_CMD 7'h04
`define PH_WSET 7'h08
`define PH_ACC 7'h10
`define PH_RDY 7'h20
`define PH_HOLD 7'h40

// chip-select timing configuration fields (16-bit word)
`define CFG_AB_LSB 0
`define CFG_AB_EXT_LSB 1
`define CFG_C_LSB 3
`define CFG_D_BIT 5
`define CFG_E_LSB 6
`define CFG_F_LSB 11
`define CFG_RDY_EN_BIT 13
`define CFG_RDY_ASYNC_BIT 14

// register port map
`define REG_CFG0 4'h0
`define REG_CFG1 4'h1
`define REG_CFG2 4'h2
`define REG_CFG3 4'h3
`define REG_STATUS 4'h4

// reset values and timing
`define CFG_RESET 16'h0000
`define UNIT_DIV_RESET 8'h00
`define REG_UNIT_DIV 4'h5

`endif

// ===== phase_timer.v
// phase_timer: counts bus-timing clock units for the current phase
// assumes the parent's tick is high in the last clock of each bus-timing unit
`timescale 1ns/1ps
`default_nettype none

module phase_timer (
    // clock and reset
    input wire i_mclk,
    input wire i_rst_b,
    // control
    input wire i_load,
    input wire [5:0] i_len,
    input wire i_tick,
    // status
    output reg o_done
);

    reg [5:0] remain;

    // ****************
    // unit countdown
    // ****************
    // load wins over a tick so a new phase always starts with its full length
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            remain <= 6'h00;
        end else if (i_load) begin
            remain <= i_len;
        end else if (i_tick && remain != 6'h00) begin
            remain <= remain - 6'h01;
        end
    end

    // done in the last clock of the last unit, so the parent moves on with no dead clock
    always @* begin
        o_done = i_tick && (remain == 6'h01);
    end

endmodule // phase_timer

`default_nettype wire

// ===== bus_cycle_sequencer_asserts.sv
// checker for the bus cycle sequencer ports
// assumes one clock domain and an async active-low reset
`timescale 1ns/1ps
`default_nettype none
module bus_cycle_sequencer_asserts (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_b,
    // watched ports
    input wire logic i_reg_rd,
    input wire logic [15:0] o_reg_rdata,
    input wire logic o_busy,
    input wire logic o_done,
    input wire logic [23:0] o_bus_addr,
    input wire logic [3:0] o_cs_b,
    input wire logic o_rd_b,
    input wire logic o_wr_b,
    input wire logic o_data_oe
);
    // ****************************************
    // bus cycle properties
    // ****************************************
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);
    AST_ONE_STROBE: assert property (o_rd_b || o_wr_b)
        else $error("read and write strobe low together");
    AST_CS_ONEHOT: assert property ($onehot0(~o_cs_b))
        else $error("more than one chip select low");
    AST_STROBE_IN_CYCLE: assert property (!(o_rd_b && o_wr_b) |-> o_cs_b != 4'hF && o_busy)
        else $error("strobe low outside a selected cycle");
    AST_SETUP_FIRST: assert property ($fell(o_rd_b) || $fell(o_wr_b) |-> $past(o_cs_b) != 4'hF)
        else $error("strobe fell without address setup");
    AST_ADDR_STABLE: assert property (!o_rd_b ##1 !o_rd_b |-> $stable(o_bus_addr))
        else $error("address moved under read strobe");
    AST_WR_DRIVES: assert property (!o_wr_b |-> o_data_oe)
        else $error("write strobe without data drive");
    AST_RD_FLOATS: assert property (!o_rd_b |-> !o_data_oe)
        else $error("data driven during read");
    AST_DONE_END: assert property (o_done |-> o_cs_b == 4'hF ##1 !o_done)
        else $error("done pulse wrong");
    AST_CYCLE_BOUND: assert property ($rose(o_busy) |-> ##[1:1000] o_done)
        else $error("bus cycle did not end");
    AST_RELEASE_BUSY: assert property ($rose(o_rd_b) || $rose(o_wr_b) |-> $past(o_busy))
        else $error("strobe released after cycle end");
    AST_RDATA_IDLE: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 16'h0000)
        else $error("register read data outside read slot");
endmodule // bus_cycle_sequencer_asserts
bind bus_cycle_sequencer bus_cycle_sequencer_asserts chk_inst (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_busy(o_busy), .o_done(o_done),
    .o_bus_addr(o_bus_addr), .o_cs_b(o_cs_b), .o_rd_b(o_rd_b), .o_wr_b(o_wr_b), .o_data_oe(o_data_oe));
`default_nettype wire

// ===== ext_mem_model.sv
// small external memory with a slow handshake
// assumes the sequencer runs one unit per clock
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
    // clock and bus
    input wire logic i_mclk,
    input wire logic [23:0] i_bus_addr,
    input wire logic i_rd_b,
    input wire logic i_wr_b,
    input wire logic [15:0] i_data,
    // not-ready cycles, set by the bench
    input wire logic [3:0] i_wait,
    // answers
    output logic [15:0] o_data,
    output logic o_ready_b
);
    // ****************************************
    // storage and handshake
    // ****************************************
    logic [15:0] mem [0:15];
    logic [15:0] junk = 16'h0000;
    logic [3:0] cnt = 4'h0;
    // last write cycle wins; count strobe-low cycles
    always @(posedge i_mclk) begin
        junk <= ~junk;
        if (!i_wr_b) mem[i_bus_addr[3:0]] <= i_data;
        cnt <= (i_rd_b && i_wr_b) ? 4'h0 : ((cnt == 4'hF) ? cnt : cnt + 4'h1);
    end
    // data only under read strobe, a moving pattern otherwise
    assign o_data = !i_rd_b ? mem[i_bus_addr[3:0]] : junk;
    // stay not ready until the wait count elapses
    assign o_ready_b = !(!(i_rd_b && i_wr_b) && cnt >= i_wait);
endmodule // ext_mem_model
`default_nettype wire

// ===== bus_cycle_sequencer_tb.sv
// bench for the bus cycle sequencer with an external memory model
// assumes unit divider left at one clock per unit
`timescale 1ns/1ps
`default_nettype none
`include "bus_seq_defines.vh"
module bus_cycle_sequencer_tb;
    // ****************************************
    // stimulus and wiring
    // ****************************************
    logic i_mclk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [3:0] i_reg_addr = 4'h0;
    logic [15:0] i_reg_wdata = 16'h0000;
    logic i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_req = 1'b0, i_req_write = 1'b0;
    logic [1:0] i_req_cs = 2'h0;
    logic [3:0] wait_n = 4'h0;
    wire [15:0] o_reg_rdata, o_rdata, o_data_out, i_data_in;
    wire [23:0] o_bus_addr;
    wire [3:0] o_cs_b;
    wire o_busy, o_done, o_rd_b, o_wr_b, o_data_oe, i_ready_b, o_upper_byte_enable_b;
    int n_fail = 0, check_count = 0, cyc = 0, ts, tl, th, bs, bl, bh;
    logic [15:0] cf [5] = '{16'h0018, 16'h0020, 16'h0001, 16'h07C0, 16'h1800};
    int ds [5] = '{3, 1, 1, 0, 0};
    int dl [5] = '{0, 0, 0, 31, 0};
    int dh [5] = '{0, 0, 0, 0, 3};
    always #5 i_mclk = ~i_mclk;
    bus_cycle_sequencer bus_cycle_sequencer_inst (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .o_reg_rdata(o_reg_rdata), .i_req(i_req), .i_req_write(i_req_write), .i_req_cs(i_req_cs),
        .i_req_addr(24'h000003), .i_req_wdata(16'hA5C3), .i_req_upper(i_req_write), .o_busy(o_busy),
        .o_done(o_done), .o_rdata(o_rdata), .o_bus_addr(o_bus_addr), .o_cs_b(o_cs_b), .o_rd_b(o_rd_b),
        .o_wr_b(o_wr_b), .o_upper_byte_enable_b(o_upper_byte_enable_b), .o_data_out(o_data_out),
        .o_data_oe(o_data_oe),
        .i_data_in(i_data_in), .i_ready_b(i_ready_b));
    ext_mem_model ext_mem_model_inst (.i_mclk(i_mclk), .i_bus_addr(o_bus_addr), .i_rd_b(o_rd_b),
        .i_wr_b(o_wr_b), .i_data(o_data_out), .i_wait(wait_n), .o_data(i_data_in), .o_ready_b(i_ready_b));
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic wrap_up;
        if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_mclk);
        i_reg_wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge i_mclk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_mclk);
        i_reg_rd <= 1'b0;
        #1 chk("reg", o_reg_rdata, e);
    endtask
    // one bus cycle; phase lengths counted in clocks
    task automatic run(input logic w, input logic [1:0] cs);
        @(posedge i_mclk);
        i_req <= 1'b1;
        i_req_write <= w;
        i_req_cs <= cs;
        @(posedge i_mclk);
        i_req <= 1'b0;
        {ts, tl, th} = '0;
        #1;
        while (o_done !== 1'b1) begin
            if (o_cs_b !== 4'hF && o_rd_b === 1'b1 && o_wr_b === 1'b1) begin
                if (tl == 0) ts++;
                else th++;
            end
            if (o_rd_b !== 1'b1 || o_wr_b !== 1'b1) tl++;
            chk("select", {o_cs_b, o_upper_byte_enable_b}, {~(4'h1 << cs), !w});
            @(posedge i_mclk);
            #1;
        end
    endtask
    task automatic t_regs;
        reg_rd(`REG_STATUS, 16'h0001);
        reg_rd(`REG_CFG0, `CFG_RESET);
        reg_wr(`REG_CFG2, 16'h2A5A);
        reg_rd(`REG_CFG2, 16'h2A5A);
        reg_rd(4'h9, 16'h0000);
    endtask
    // each field moves only its own phase, measured against a minimal cycle
    task automatic t_phases;
        reg_wr(`REG_CFG0, 16'h0000);
        run(1'b1, 2'h0);
        run(1'b1, 2'h0);
        {bs, bl, bh} = {ts, tl, th};
        foreach (cf[i]) begin
            reg_wr(`REG_CFG0, cf[i]);
            run(1'b1, 2'h0);
            chk("setup", ts - bs, ds[i]);
            chk("access", tl - bl, dl[i]);
            chk("hold", th - bh, dh[i]);
        end
        reg_wr(`REG_CFG1, 16'h0006);
        run(1'b1, 2'h1);
        chk("window", ts - bs, 3);
        run(1'b1, 2'h1);
        chk("same_window", ts - bs, 0);
    endtask
    // waitstates from a slow handshake, in both sampling modes
    task automatic t_ready;
        reg_wr(`REG_CFG0, 16'h2000);
        wait_n <= 4'h2;
        run(1'b0, 2'h0);
        bl = tl;
        wait_n <= 4'h8;
        run(1'b0, 2'h0);
        chk("waits", tl - bl, 6);
        chk("rdata", o_rdata, 16'hA5C3);
        bh = tl;
        reg_wr(`REG_CFG0, 16'h6000);
        run(1'b0, 2'h0);
        chk("async_later", tl - bh, 1);
    endtask
    // a divider of one stretches every unit to two clocks
    task automatic t_div;
        reg_wr(`REG_UNIT_DIV, 16'h0001);
        reg_rd(`REG_UNIT_DIV, 16'h0001);
        reg_wr(`REG_CFG0, 16'h0000);
        run(1'b1, 2'h0);
        chk("div_setup", ts, 2);
        chk("div_access", tl, 2);
        reg_wr(`REG_UNIT_DIV, 16'h0000);
    endtask
    initial begin
        repeat (10) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        t_regs;
        t_phases;
        t_ready;
        t_div;
        wrap_up;
    end
    // hang guard, far above the expected run of well under a thousand clocks
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            wrap_up;
        end
    end
endmodule // bus_cycle_sequencer_tb
`default_nettype wire
